// ### rtl/tsr_timing.v
// touch sampling timing, hold/repeat timers and forced recalibration control
// Summary of operation
// - max_touch_duration bits 7-4 select recalibration time
// - repeat_interval spaces repeat interrupts, (n+1)x35ms
// - hold_threshold_time bits 3-0, 35ms steps, reset 280ms
// - touch longer than threshold is press-and-hold; hold_q is set only for inputs with auto_repeat_enable set
// - samples_per_measurement selects 1 to 128 samples
// - channel samples back to back, then averaged
// - sample_period_sel selects single sample duration
// - polling_period_sel selects overall polling cycle period
// - measure at cycle start, then low power
// - sample count stretches cycle when needed
// - sensing settings apply in active state
// - timing settings common to all six inputs
// - writing one starts input recalibration
// - no press, base invalid during recalibration
// - press during forced recalibration invalidates the attempt
// - completed recalibration updates calibration_value
// - request bit self clears after successful recalibration
// - duration recalibration only when enable is set
// - repeat interrupts while auto-repeat hold continues
`include "tsr_map.vh"
module tsr_timing #(
	parameter NCH      = 6,
	parameter SAMPLE_W = 16,
	parameter TICK_DIV = `TSR_CLK_KHZ / 200, // cycles per 5us tick
	parameter MS_TICKS = 1000 / `TSR_TICK_US, // ticks per ms
	parameter RECAL_MS = `TSR_RECAL_MAX_MS
) (
	// clock and reset
	input  wire                  core_clk,
	input  wire                  sys_rst,
	// register port
	input  wire [7:0]            reg_addr,
	input  wire                  reg_wr,
	input  wire [7:0]            reg_wdata,
	output wire [7:0]            reg_rdata,
	// configuration from outside this block
	input  wire                  active_state,
	input  wire [NCH-1:0]        input_enable,
	input  wire [NCH-1:0]        auto_repeat_enable,
	input  wire                  duration_recal_enable,
	// analog front end
	output reg                   sample_start_q,
	output reg  [2:0]            sample_chan_q,
	input  wire                  sample_valid,
	input  wire [SAMPLE_W-1:0]   sample_data,
	input  wire [NCH-1:0]        raw_touch,
	output reg  [NCH-1:0]        afe_recal_q,
	input  wire [NCH-1:0]        afe_recal_done,
	input  wire [9:0]            afe_cal_value,
	// results
	output reg  [SAMPLE_W-1:0]   meas_result_q,
	output reg  [2:0]            meas_chan_q,
	output reg                   meas_valid_q,
	output reg                   low_power_q,
	output reg  [NCH-1:0]        press_q,
	output reg  [NCH-1:0]        hold_q,
	output reg  [NCH-1:0]        touch_event_q,
	output reg  [NCH-1:0]        repeat_event_q,
	output reg  [NCH-1:0]        base_valid_q,
	output reg  [NCH*10-1:0]     calibration_value_q
);
	localparam S_IDLE = 3'b001;
	localparam S_SAMP = 3'b010;
	localparam S_WAIT = 3'b100;
	localparam CW     = 20;

	reg [7:0]     touch_cfg_q;
	reg [7:0]     hold_cfg_q;
	reg [7:0]     avg_cfg_q;
	reg [NCH-1:0] recal_req_q;
	// one-cycle strobe from a completed recalibration, clears its request bit
	reg [NCH-1:0] recal_ok_q;

	// 35ms step count: (code+1) x 35
	function [CW-1:0] step_ms;
		input [3:0] code;
		begin
			step_ms = ({16'h0000, code} + 20'h00001) * `TSR_STEP_MS;
		end
	endfunction

	// max duration decode in ms
	function [CW-1:0] maxdur_ms;
		input [3:0] code;
		begin
			case (code)
			4'h0: maxdur_ms = 20'd560;
			4'h1: maxdur_ms = 20'd840;
			4'h2: maxdur_ms = 20'd1120;
			4'h3: maxdur_ms = 20'd1400;
			4'h4: maxdur_ms = 20'd1680;
			4'h5: maxdur_ms = 20'd2240;
			4'h6: maxdur_ms = 20'd2800;
			4'h7: maxdur_ms = 20'd3360;
			4'h8: maxdur_ms = 20'd3920;
			4'h9: maxdur_ms = 20'd4480;
			4'ha: maxdur_ms = 20'd5600;
			4'hb: maxdur_ms = 20'd6720;
			4'hc: maxdur_ms = 20'd7840;
			4'hd: maxdur_ms = 20'd8906;
			4'he: maxdur_ms = 20'd10080;
			default: maxdur_ms = 20'd11200;
			endcase
		end
	endfunction

	// register writes; recal bits self clear, write of one wins over clear
	integer i;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			touch_cfg_q <= `TSR_RST_TOUCH_TIMING;
			hold_cfg_q  <= `TSR_RST_HOLD_TIMING;
			avg_cfg_q   <= `TSR_RST_AVG_SAMPLING;
			recal_req_q <= {NCH{1'b0}};
		end else begin
			if (reg_wr && reg_addr == `TSR_ADDR_TOUCH_TIMING)
				touch_cfg_q <= reg_wdata;
			if (reg_wr && reg_addr == `TSR_ADDR_HOLD_TIMING)
				hold_cfg_q <= reg_wdata;
			if (reg_wr && reg_addr == `TSR_ADDR_AVG_SAMPLING)
				avg_cfg_q <= reg_wdata;
			for (i = 0; i < NCH; i = i + 1) begin
				if (reg_wr && reg_addr == `TSR_ADDR_RECAL_REQ && reg_wdata[i])
					recal_req_q[i] <= 1'b1;
				else if (recal_ok_q[i])
					recal_req_q[i] <= 1'b0;
			end
		end
	end

	// read mux
	assign reg_rdata =
		(reg_addr == `TSR_ADDR_TOUCH_TIMING) ? touch_cfg_q :
		// bit 4 of the hold register is reserved and reads zero
		(reg_addr == `TSR_ADDR_HOLD_TIMING)  ? (hold_cfg_q & `TSR_HOLD_RW_BITS) :
		(reg_addr == `TSR_ADDR_AVG_SAMPLING) ? {1'b0, avg_cfg_q[6:0]} :
		(reg_addr == `TSR_ADDR_RECAL_REQ)    ? {{(8-NCH){1'b0}}, recal_req_q} : 8'h00;

	// common 5us tick and 1ms tick
	reg [15:0] div_q;
	reg [15:0] us_cnt_q;
	reg        tick_q;
	reg        ms_q;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q    <= 16'h0000;
			us_cnt_q <= 16'h0000;
			tick_q   <= 1'b0;
			ms_q     <= 1'b0;
		end else begin
			tick_q <= (div_q == TICK_DIV[15:0] - 16'h0001);
			div_q  <= (div_q == TICK_DIV[15:0] - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
			ms_q   <= 1'b0;
			if (tick_q) begin
				if (us_cnt_q == MS_TICKS[15:0] - 16'h0001) begin
					us_cnt_q <= 16'h0000;
					ms_q     <= 1'b1;
				end else
					us_cnt_q <= us_cnt_q + 16'h0001;
			end
		end
	end

	// sample length in 5us ticks and poll period in ms
	wire [1:0]  samp_sel = avg_cfg_q[`TSR_SAMP_HI:`TSR_SAMP_LO];
	wire [1:0]  poll_sel = avg_cfg_q[`TSR_POLL_HI:`TSR_POLL_LO];
	wire [2:0]  avg_sel  = avg_cfg_q[`TSR_AVG_HI:`TSR_AVG_LO];
	// shortest sample in 5us ticks, doubled per code step
	wire [15:0] samp_ticks = `TSR_SAMPLE_TICKS << samp_sel;
	wire [CW-1:0] poll_ms = step_ms({2'b00, poll_sel});
	wire [7:0]  avg_last = (8'h01 << avg_sel) - 8'h01;

	// polling sequencer
	reg [2:0]          st_q;
	reg [2:0]          ch_q;
	reg [7:0]          n_q;
	reg [15:0]         st_cnt_q;
	reg [CW-1:0]       cyc_ms_q;
	reg [SAMPLE_W+7:0] acc_q;
	reg                busy_q;
	// running sum and its average; the sum holds 128 full-scale samples
	wire [SAMPLE_W+7:0] acc_sum = acc_q + {8'h00, sample_data};
	wire [SAMPLE_W+7:0] acc_avg = acc_sum >> avg_sel;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= S_IDLE;
			ch_q <= 3'h0;
			n_q <= 8'h00;
			st_cnt_q <= 16'h0000;
			cyc_ms_q <= {CW{1'b0}};
			acc_q <= {(SAMPLE_W+8){1'b0}};
			busy_q <= 1'b0;
			sample_start_q <= 1'b0;
			sample_chan_q <= 3'h0;
			meas_valid_q <= 1'b0;
			meas_result_q <= {SAMPLE_W{1'b0}};
			meas_chan_q <= 3'h0;
			low_power_q <= 1'b0;
		end else begin
			sample_start_q <= 1'b0;
			meas_valid_q <= 1'b0;
			if (ms_q && st_q != S_IDLE)
				cyc_ms_q <= cyc_ms_q + {{(CW-1){1'b0}}, 1'b1};
			case (st_q)
			S_IDLE: begin
				low_power_q <= 1'b0;
				if (active_state) begin
					st_q <= S_SAMP;
					cyc_ms_q <= {CW{1'b0}};
					ch_q <= 3'h0;
					n_q <= 8'h00;
					acc_q <= {(SAMPLE_W+8){1'b0}};
					busy_q <= 1'b0;
				end
			end
			S_SAMP: begin
				if (ch_q >= NCH[2:0]) begin
					st_q <= S_WAIT;
					low_power_q <= 1'b1;
				end else if (!input_enable[ch_q]) begin
					ch_q <= ch_q + 3'h1;
				end else if (!busy_q) begin
					sample_start_q <= 1'b1;
					sample_chan_q <= ch_q;
					st_cnt_q <= 16'h0000;
					busy_q <= 1'b1;
				end else begin
					if (tick_q && st_cnt_q < samp_ticks)
						st_cnt_q <= st_cnt_q + 16'h0001;
					if (sample_valid && st_cnt_q >= samp_ticks) begin
						busy_q <= 1'b0;
						if (n_q == avg_last) begin
							meas_result_q <= acc_avg[SAMPLE_W-1:0];
							meas_chan_q <= ch_q;
							meas_valid_q <= 1'b1;
							acc_q <= {(SAMPLE_W+8){1'b0}};
							n_q <= 8'h00;
							ch_q <= ch_q + 3'h1;
						end else begin
							acc_q <= acc_sum;
							n_q <= n_q + 8'h01;
						end
					end
				end
			end
			S_WAIT: begin
				// stretched cycle ends at once when sampling ran past the period
				if (cyc_ms_q >= poll_ms || !active_state) begin
					st_q <= S_IDLE;
					low_power_q <= 1'b0;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// per-input touch, hold, repeat and recalibration timers
	reg [CW-1:0] dur_q [0:NCH-1];
	reg [CW-1:0] rpt_q [0:NCH-1];
	reg [CW-1:0] rcl_q [0:NCH-1];
	reg [NCH-1:0] recal_run_q;
	reg [NCH-1:0] recal_forced_q;
	// pending or running recalibration: press and touch timing held off
	wire [NCH-1:0] sense_block = recal_run_q | recal_req_q;
	wire [CW-1:0] hold_ms = step_ms(hold_cfg_q[`TSR_NIB_HI:`TSR_NIB_LO]);
	wire [CW-1:0] rpt_ms  = step_ms(touch_cfg_q[`TSR_NIB_HI:`TSR_NIB_LO]);
	wire [CW-1:0] max_ms  = maxdur_ms(touch_cfg_q[`TSR_MAXDUR_HI:`TSR_MAXDUR_LO]);
	integer k;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (k = 0; k < NCH; k = k + 1) begin
				dur_q[k] <= {CW{1'b0}};
				rpt_q[k] <= {CW{1'b0}};
				rcl_q[k] <= {CW{1'b0}};
			end
			recal_run_q <= {NCH{1'b0}};
			recal_forced_q <= {NCH{1'b0}};
			recal_ok_q <= {NCH{1'b0}};
			afe_recal_q <= {NCH{1'b0}};
			press_q <= {NCH{1'b0}};
			hold_q <= {NCH{1'b0}};
			touch_event_q <= {NCH{1'b0}};
			repeat_event_q <= {NCH{1'b0}};
			base_valid_q <= {NCH{1'b1}};
			calibration_value_q <= {(NCH*10){1'b0}};
		end else begin
			recal_ok_q <= {NCH{1'b0}};
			afe_recal_q <= {NCH{1'b0}};
			touch_event_q <= {NCH{1'b0}};
			repeat_event_q <= {NCH{1'b0}};
			for (k = 0; k < NCH; k = k + 1) begin
				// a pending request masks the pad until its recalibration completes
				press_q[k] <= raw_touch[k] && !sense_block[k];
				base_valid_q[k] <= !recal_run_q[k];
				if (!raw_touch[k] || sense_block[k]) begin
					dur_q[k] <= {CW{1'b0}};
					rpt_q[k] <= {CW{1'b0}};
					if (press_q[k] && !hold_q[k])
						touch_event_q[k] <= 1'b1;
					hold_q[k] <= 1'b0;
				end else if (ms_q) begin
					dur_q[k] <= dur_q[k] + {{(CW-1){1'b0}}, 1'b1};
					if (dur_q[k] >= hold_ms && auto_repeat_enable[k] && !hold_q[k]) begin
						hold_q[k] <= 1'b1;
						repeat_event_q[k] <= 1'b1;
						rpt_q[k] <= {CW{1'b0}};
					end else if (hold_q[k]) begin
						if (rpt_q[k] + {{(CW-1){1'b0}}, 1'b1} >= rpt_ms) begin
							repeat_event_q[k] <= 1'b1;
							rpt_q[k] <= {CW{1'b0}};
						end else
							rpt_q[k] <= rpt_q[k] + {{(CW-1){1'b0}}, 1'b1};
					end
				end
				// forced attempts wait for a free pad; duration ones start under the held touch
				if (!recal_run_q[k] && ((recal_req_q[k] && !raw_touch[k]) ||
				    (duration_recal_enable && raw_touch[k] && dur_q[k] >= max_ms))) begin
					recal_run_q[k] <= 1'b1;
					recal_forced_q[k] <= recal_req_q[k];
					afe_recal_q[k] <= 1'b1;
					rcl_q[k] <= {CW{1'b0}};
				end else if (recal_run_q[k]) begin
					if (ms_q)
						rcl_q[k] <= rcl_q[k] + {{(CW-1){1'b0}}, 1'b1};
					// a press spoils a forced attempt; the held touch is what a duration
					// attempt absorbs, so only the time limit ends that one early
					if ((recal_forced_q[k] && raw_touch[k]) || rcl_q[k] >= RECAL_MS[CW-1:0]) begin
						recal_run_q[k] <= 1'b0; // attempt invalid, request stays set
						recal_forced_q[k] <= 1'b0;
					end else if (afe_recal_done[k]) begin
						recal_run_q[k] <= 1'b0;
						recal_forced_q[k] <= 1'b0;
						recal_ok_q[k] <= 1'b1;
						calibration_value_q[k*10 +: 10] <= afe_cal_value;
					end
				end
			end
		end
	end
endmodule

// ### rtl/tsr_map.vh
// register map, field positions and timing constants for touch timing/recal block
`ifndef TSR_MAP_VH
`define TSR_MAP_VH
`define TSR_ADDR_TOUCH_TIMING  8'h22
`define TSR_ADDR_HOLD_TIMING   8'h23
`define TSR_ADDR_AVG_SAMPLING  8'h24
`define TSR_ADDR_RECAL_REQ     8'h26
`define TSR_RST_TOUCH_TIMING   8'ha4
`define TSR_RST_HOLD_TIMING    8'h07
`define TSR_RST_AVG_SAMPLING   8'h39
`define TSR_RST_RECAL_REQ      8'h00
`define TSR_HOLD_RW_BITS       8'hef
`define TSR_MAXDUR_HI          7
`define TSR_MAXDUR_LO          4
`define TSR_NIB_HI             3
`define TSR_NIB_LO             0
`define TSR_AVG_HI             6
`define TSR_AVG_LO             4
`define TSR_SAMP_HI            3
`define TSR_SAMP_LO            2
`define TSR_POLL_HI            1
`define TSR_POLL_LO            0
`define TSR_CLK_KHZ            200000
`define TSR_TICK_US            5
`define TSR_SAMPLE_BASE_US     320
`define TSR_SAMPLE_TICKS       16'h0040
`define TSR_STEP_MS            20'h00023
`define TSR_RECAL_MAX_MS       600
`endif

// ### testbench/tsr_timing_assertions.sv
// concurrent checks on the ports of the touch timing and recalibration block
module tsr_timing_checker (
	// clock and reset
	input wire        core_clk,
	input wire        sys_rst,
	// register port
	input wire [7:0]  reg_addr,
	input wire        reg_wr,
	input wire [7:0]  reg_wdata,
	// front end and results
	input wire        sample_start_q,
	input wire        sample_valid,
	input wire        meas_valid_q,
	input wire        low_power_q,
	input wire [5:0]  auto_repeat_enable,
	input wire [5:0]  raw_touch,
	input wire [5:0]  afe_recal_q,
	input wire [5:0]  afe_recal_done,
	input wire [5:0]  press_q,
	input wire [5:0]  hold_q,
	input wire [5:0]  touch_event_q,
	input wire [5:0]  repeat_event_q,
	input wire [5:0]  base_valid_q,
	input wire [59:0] calibration_value_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// sequencing of samples and averaged results
	property p_meas; meas_valid_q |-> $past(sample_valid); endproperty
	property p_start; sample_start_q |=> !sample_start_q; endproperty
	property p_idle; low_power_q |-> !sample_start_q && !meas_valid_q; endproperty
	// recalibration masking, start and completion
	property p_mask; |afe_recal_q |=> (press_q & $past(afe_recal_q)) == 6'h00; endproperty
	property p_rbase; |afe_recal_q |=> (base_valid_q & $past(afe_recal_q)) == 6'h00; endproperty
	property p_req; reg_wr && reg_addr == 8'h26 && reg_wdata[5:0] != 6'h00 && &base_valid_q
		&& raw_touch == 6'h00 ##1 raw_touch == 6'h00 |=> afe_recal_q != 6'h00; endproperty
	property p_cal; $changed(calibration_value_q) |-> $past(|afe_recal_done); endproperty
	// touch classification and repeat events
	property p_tev; |touch_event_q |-> (touch_event_q & $past(hold_q)) == 6'h00; endproperty
	property p_rpt; (repeat_event_q & ~auto_repeat_enable) == 6'h00; endproperty
	a_meas: assert property (p_meas) else $error("result without sample");
	a_start: assert property (p_start) else $error("sample start too long");
	a_idle: assert property (p_idle) else $error("activity in low power");
	a_mask: assert property (p_mask) else $error("press while base invalid");
	a_rbase: assert property (p_rbase) else $error("base valid during recal");
	a_req: assert property (p_req) else $error("recal request not started");
	a_cal: assert property (p_cal) else $error("cal value changed unprompted");
	a_tev: assert property (p_tev) else $error("touch event after hold");
	a_rpt: assert property (p_rpt) else $error("repeat without auto repeat");
	c_meas: cover property (meas_valid_q);
	c_lp: cover property ($rose(low_power_q));
	c_rpt: cover property (|repeat_event_q);
	c_tev: cover property (|touch_event_q);
endmodule
bind tsr_timing tsr_timing_checker tsr_timing_checker_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .sample_start_q(sample_start_q),
	.sample_valid(sample_valid), .meas_valid_q(meas_valid_q), .low_power_q(low_power_q),
	.auto_repeat_enable(auto_repeat_enable), .raw_touch(raw_touch), .afe_recal_q(afe_recal_q),
	.afe_recal_done(afe_recal_done), .press_q(press_q), .hold_q(hold_q),
	.touch_event_q(touch_event_q), .repeat_event_q(repeat_event_q),
	.base_valid_q(base_valid_q), .calibration_value_q(calibration_value_q));

// ### testbench/tsr_front_model.sv
// behavioural analog front end: answers samples and recalibration requests
module tsr_front_model #(
	parameter       SDLY = 132,
	parameter       RDLY = 40,
	parameter [9:0] CAL  = 10'h2a5
) (
	input  wire        core_clk,
	input  wire        sample_start,
	input  wire [2:0]  sample_chan,
	output reg         sample_valid,
	output reg  [15:0] sample_data,
	input  wire [5:0]  afe_recal,
	output reg  [5:0]  afe_recal_done,
	output reg  [9:0]  afe_cal_value
);
	timeunit 1ns;
	timeprecision 1ps;
	int         scnt = 0;
	int         rcnt [6] = '{0, 0, 0, 0, 0, 0};
	logic       odd = 1'b0;
	logic       st;
	logic [5:0] rq;
	initial begin
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		afe_recal_done = 6'h00;
		afe_cal_value = 10'h000;
	end
	// sample data alternates 0 and 2 above the channel base; data churns when not valid
	always @(posedge core_clk) begin
		st = sample_start;
		rq = afe_recal;
		#1;
		sample_valid = 1'b0;
		afe_recal_done = 6'h00;
		sample_data = ~sample_data;
		afe_cal_value = ~afe_cal_value;
		if (st) scnt = SDLY;
		else if (scnt > 0) begin
			scnt--;
			if (scnt == 0) begin
				sample_valid = 1'b1;
				sample_data = {5'h00, sample_chan, 8'h00} + (odd ? 16'h0002 : 16'h0000);
				odd = ~odd;
			end
		end
		// a new request restarts that input's recalibration
		for (int k = 0; k < 6; k++) begin
			if (rq[k]) rcnt[k] = RDLY;
			else if (rcnt[k] > 0) begin
				rcnt[k]--;
				if (rcnt[k] == 0) begin
					afe_recal_done[k] = 1'b1;
					afe_cal_value = CAL + 10'(k);
				end
			end
		end
	end
endmodule

// ### testbench/tsr_timing_bench.sv
// self-checking bench for the touch timing and recalibration block
module tsr_timing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	logic        reg_wr = 1'b0, active_state = 1'b0, duration_recal_enable = 1'b0;
	logic [5:0]  input_enable = 6'h05, auto_repeat_enable = 6'h3f, raw_touch = 6'h00;
	wire  [7:0]  reg_rdata;
	wire         sample_start_q, sample_valid, meas_valid_q, low_power_q;
	wire  [2:0]  sample_chan_q, meas_chan_q;
	wire  [15:0] sample_data, meas_result_q;
	wire  [5:0]  afe_recal_q, afe_recal_done, press_q, hold_q, touch_event_q, repeat_event_q;
	wire  [5:0]  base_valid_q;
	wire  [9:0]  afe_cal_value;
	wire  [59:0] calibration_value_q;
	int          errors = 0, num_checks = 0, n;
	logic [18:0] mq [$];
	tsr_timing #(.TICK_DIV(2), .MS_TICKS(2)) tsr_timing_i (.core_clk, .sys_rst, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rdata, .active_state, .input_enable, .auto_repeat_enable,
		.duration_recal_enable, .sample_start_q, .sample_chan_q, .sample_valid, .sample_data,
		.raw_touch, .afe_recal_q, .afe_recal_done, .afe_cal_value, .meas_result_q, .meas_chan_q,
		.meas_valid_q, .low_power_q, .press_q, .hold_q, .touch_event_q, .repeat_event_q,
		.base_valid_q, .calibration_value_q);
	tsr_front_model tsr_front_model_i (.core_clk, .sample_start(sample_start_q),
		.sample_chan(sample_chan_q), .sample_valid, .sample_data, .afe_recal(afe_recal_q),
		.afe_recal_done, .afe_cal_value);
	// clock and result capture
	initial forever #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (meas_valid_q === 1'b1) mq.push_back({meas_chan_q, meas_result_q});
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		tick(1);
		chk(reg_rdata, e);
	endtask
	task give_verdict;
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// reset values, unmapped address, fixed bits, then set up short timings
	task t_regs;
		rdc(8'h22, 8'ha4);
		rdc(8'h23, 8'h07);
		rdc(8'h24, 8'h39);
		rdc(8'h26, 8'h00);
		rdc(8'h25, 8'h00);
		wr(8'h22, 8'hd0);
		rdc(8'h22, 8'hd0);
		wr(8'h23, 8'hf0);
		rdc(8'h23, 8'he0);
		wr(8'h24, 8'h93);
		rdc(8'h24, 8'h13);
	endtask
	// two samples per channel, channel order, average and idle after sampling
	task t_avg;
		mq.delete();
		active_state = 1'b1;
		for (int i = 0; i < 5000 && mq.size() < 2; i++) tick(1);
		chk(mq[0], {3'd0, 16'h0001});
		chk(mq[1], {3'd2, 16'h0201});
		for (int i = 0; i < 100 && low_power_q !== 1'b1; i++) tick(1);
		chk(low_power_q, 1'b1);
	endtask
	// short touch gives a touch event, long one a hold with repeats every 35 ms
	task t_hold;
		raw_touch[1] = 1'b1;
		tick(40);
		chk(hold_q[1], 1'b0);
		raw_touch[1] = 1'b0;
		n = 0;
		repeat (20) begin
			tick(1);
			n += touch_event_q[1];
		end
		chk(n, 1);
		raw_touch[1] = 1'b1;
		n = 0;
		for (int i = 1; i <= 400; i++) begin
			tick(1);
			n += repeat_event_q[1];
			if (i == 120) chk(hold_q[1], 1'b0);
			if (i == 170) chk(hold_q[1], 1'b1);
		end
		chk(n, 2);
		raw_touch[1] = 1'b0;
		tick(20);
	endtask
	// forced recalibration, then one spoiled by a press
	task t_recal;
		wr(8'h26, 8'h08);
		tick(5);
		chk(base_valid_q[3], 1'b0);
		for (int i = 0; i < 200 && reg_rdata !== 8'h00; i++) tick(1);
		chk(reg_rdata, 8'h00);
		chk(calibration_value_q[39:30], 10'h2a8);
		chk(base_valid_q, 6'h3f);
		wr(8'h26, 8'h10);
		tick(5);
		raw_touch[4] = 1'b1;
		tick(60);
		chk(press_q[4], 1'b0);
		rdc(8'h26, 8'h10);
		raw_touch[4] = 1'b0;
		for (int i = 0; i < 3000 && reg_rdata !== 8'h00; i++) tick(1);
		chk(reg_rdata, 8'h00);
	endtask
	// a touch held past the maximum duration recalibrates only while enabled
	task t_dur;
		wr(8'h22, 8'h00);
		raw_touch[0] = 1'b1;
		tick(2300);
		chk(base_valid_q[0], 1'b1);
		chk(calibration_value_q[9:0], 10'h000);
		duration_recal_enable = 1'b1;
		for (int i = 0; i < 400 && base_valid_q[0] !== 1'b0; i++) tick(1);
		chk(base_valid_q[0], 1'b0);
		for (int i = 0; i < 200 && base_valid_q[0] !== 1'b1; i++) tick(1);
		chk(calibration_value_q[9:0], 10'h2a5);
		raw_touch[0] = 1'b0;
		duration_recal_enable = 1'b0;
		tick(20);
	endtask
	initial begin
		tick(20);
		sys_rst = 1'b0;
		t_regs();
		t_avg();
		t_hold();
		t_recal();
		t_dur();
		give_verdict();
	end
	// watchdog against a hung handshake
	initial begin
		#100us;
		errors++;
		give_verdict();
	end
endmodule
